// ==== hw/rmac_defs.svh ====
/*
 * Register offsets, reset values and widths for the register-mapped
 * multiply/accumulate unit.
 * Assumes an 8-bit register address space on the processor's data bus.
 */
`ifndef RMAC_DEFS_SVH
`define RMAC_DEFS_SVH

// ---------------------------------------------------------------------
// Register offsets
// ---------------------------------------------------------------------
`define RMAC_OFS_MULT_X 8'he8
`define RMAC_OFS_MULT_Y 8'he9
`define RMAC_OFS_PROD_HI 8'hea
`define RMAC_OFS_PROD_LO 8'heb
`define RMAC_OFS_ACC_B1 8'hec
`define RMAC_OFS_ACC_B0 8'hed
`define RMAC_OFS_ACC_B3 8'hee
`define RMAC_OFS_ACC_B2 8'hef

// ---------------------------------------------------------------------
// Reset values and widths
// ---------------------------------------------------------------------
`define RMAC_RST_BYTE 8'h00
`define RMAC_RST_ACC 32'h0000_0000
`define RMAC_RD_IDLE 8'h00

`endif

// ==== hw/rmac_mult.sv ====
/*
 * Signed 8x8 multiplier, purely combinational.
 * Assumes operands are the next-state operand values, settled within the same clock.
 */
module rmac_mult (
    input wire rmac_pkg::rmac_opnd_t a_i,
    input wire rmac_pkg::rmac_opnd_t b_i,
    output rmac_pkg::rmac_prod_t p_o
);
    import rmac_pkg::*;

    // Two's complement product; 16 bits hold every signed 8x8 result.
    assign p_o = rmac_prod_t'(a_i) * rmac_prod_t'(b_i);
endmodule

// ==== hw/rmac_pkg.sv ====
/*
 * Types shared by the multiply/accumulate unit.
 * Assumes nothing beyond a SystemVerilog compiler.
 */
package rmac_pkg;
    typedef logic signed [7:0] rmac_opnd_t;
    typedef logic signed [15:0] rmac_prod_t;
    typedef logic signed [31:0] rmac_acc_t;
    typedef logic [7:0] rmac_addr_t;
    typedef logic [7:0] rmac_data_t;
endpackage

// ==== hw/rmac_top.sv ====
/*
 * Register-mapped signed multiplier and multiply/accumulate unit.
 * Assumes a single-cycle register bus from the processor core: write
 * and read strobes qualified by an address, all on sys_clk_i.
 */
// Operation
// (RULE1) Software waits one instruction before upper bytes.
// (RULE2) Low accumulator bytes valid next instruction.
// (RULE3) Product readable right after operand write.
// (RULE4) Write-only X operand at E8h.
// (RULE5) Write-only Y operand at E9h.
// (RULE6) EAh reads product upper byte.
// (RULE7) EBh reads product lower byte.
// (RULE8) ECh reads accumulator bits 15..8.
// (RULE9) ECh write loads X, starts accumulate.
// (RULE10) EDh reads accumulator bits 7..0.
// (RULE11) EDh write loads Y, starts accumulate.
// (RULE12) Clear register reads accumulator bits 31..24.
// (RULE13) Any write to it clears accumulator.
// (RULE14) Signed operands, product and accumulator.
// (RULE15) Plain operand write recomputes product only.
// (RULE16) X and Y operands shared by both paths.
// (RULE17) EFh reads bits 23..16, write clears.
// (RULE18) Upper bytes lag one cycle; space accumulates.
`include "rmac_defs.svh"

module rmac_top (
    input wire logic sys_clk_i,
    input wire logic rst_i,
    input wire logic wr_en_i,
    input wire logic rd_en_i,
    input wire rmac_pkg::rmac_addr_t addr_i,
    input wire rmac_pkg::rmac_data_t wdata_i,
    output rmac_pkg::rmac_data_t rdata_o
);
    import rmac_pkg::*;

    // -----------------------------------------------------------------
    // State
    // -----------------------------------------------------------------
    rmac_opnd_t opnd_x_q;
    rmac_opnd_t opnd_y_q;
    rmac_opnd_t opnd_x_d;
    rmac_opnd_t opnd_y_d;
    rmac_prod_t prod_q;
    rmac_prod_t prod_d;
    rmac_prod_t acc_prod_q;
    logic [15:0] acc_lo_q;
    logic [15:0] acc_hi_q;
    logic carry_q;
    logic pend_q;
    logic [16:0] lo_sum;
    logic [15:0] hi_ext;
    logic wr_x;
    logic wr_y;
    logic wr_mx;
    logic wr_my;
    logic wr_clr;
    logic acc_go;
    rmac_data_t rdata_d;

    function automatic logic hit(input rmac_addr_t a, input rmac_addr_t o);
        hit = (a == o);
    endfunction

    // -----------------------------------------------------------------
    // Write decode
    // -----------------------------------------------------------------
    // Decoded write strobes for six of the eight register offsets.
    // (RULE4) X operand decode.
    assign wr_x = wr_en_i && hit(addr_i, `RMAC_OFS_MULT_X);
    // (RULE5) Y operand decode.
    assign wr_y = wr_en_i && hit(addr_i, `RMAC_OFS_MULT_Y);
    // (RULE9) Accumulate X decode.
    assign wr_mx = wr_en_i && hit(addr_i, `RMAC_OFS_ACC_B1);
    // (RULE11) Accumulate Y decode.
    assign wr_my = wr_en_i && hit(addr_i, `RMAC_OFS_ACC_B0);
    // (RULE13) Clear strobes ignore data.
    assign wr_clr = wr_en_i && (hit(addr_i, `RMAC_OFS_ACC_B3)
                               || hit(addr_i, `RMAC_OFS_ACC_B2));
    assign acc_go = wr_mx || wr_my;

    // -----------------------------------------------------------------
    // Operands and product
    // -----------------------------------------------------------------
    // (RULE16) Shared operand update.
    always_comb begin
        opnd_x_d = opnd_x_q;
        opnd_y_d = opnd_y_q;
        if (wr_x || wr_mx) begin
            opnd_x_d = wdata_i;
        end
        if (wr_y || wr_my) begin
            opnd_y_d = wdata_i;
        end
    end

    // The product is formed from the operands about to be stored, so it
    // is ready on the cycle after the write with no extra wait.
    rmac_mult u_mult (
        .a_i(opnd_x_d),
        .b_i(opnd_y_d),
        .p_o(prod_d)
    );

    always_ff @(posedge sys_clk_i or posedge rst_i) begin
        if (rst_i) begin
            opnd_x_q <= `RMAC_RST_BYTE;
            opnd_y_q <= `RMAC_RST_BYTE;
        end else begin
            opnd_x_q <= opnd_x_d;
            opnd_y_q <= opnd_y_d;
        end
    end

    // (RULE3) Product registered at once.
    // (RULE15) Recompute on every operand write.
    always_ff @(posedge sys_clk_i or posedge rst_i) begin
        if (rst_i) begin
            prod_q <= 16'h0000;
        end else if (wr_x || wr_y || acc_go) begin
            prod_q <= prod_d;
        end
    end

    // -----------------------------------------------------------------
    // Accumulator
    // -----------------------------------------------------------------
    // (RULE14) Signed low half sum.
    assign lo_sum = {1'b0, acc_lo_q} + {1'b0, prod_d};
    // Sign extension of the stored product into the upper half.
    assign hi_ext = {16{acc_prod_q[15]}};

    // (RULE2) Low half updated immediately.
    always_ff @(posedge sys_clk_i or posedge rst_i) begin
        if (rst_i) begin
            acc_lo_q <= 16'h0000;
        end else if (wr_clr) begin
            acc_lo_q <= 16'h0000;
        end else if (acc_go) begin
            acc_lo_q <= lo_sum[15:0];
        end
    end

    // The upper half finishes one cycle later from the carry and the
    // product sign; this splits the 32-bit add to keep the path short.
    // (RULE18) Deferred upper half add.
    always_ff @(posedge sys_clk_i or posedge rst_i) begin
        if (rst_i) begin
            pend_q <= 1'b0;
            carry_q <= 1'b0;
            acc_prod_q <= 16'h0000;
        end else begin
            pend_q <= acc_go && !wr_clr;
            carry_q <= lo_sum[16];
            acc_prod_q <= prod_d;
        end
    end

    // (RULE13) Clear all four bytes.
    // (RULE17) Second clear address.
    always_ff @(posedge sys_clk_i or posedge rst_i) begin
        if (rst_i) begin
            acc_hi_q <= 16'h0000;
        end else if (wr_clr) begin
            acc_hi_q <= 16'h0000;
        end else if (pend_q) begin
            acc_hi_q <= acc_hi_q + hi_ext + {15'h0000, carry_q};
        end
    end

    // -----------------------------------------------------------------
    // Read mux
    // -----------------------------------------------------------------
    // Write-only and unmapped offsets read as zero.
    always_comb begin
        rdata_d = `RMAC_RD_IDLE;
        if (rd_en_i) begin
            unique case (addr_i)
                // (RULE6) Product upper byte.
                `RMAC_OFS_PROD_HI: rdata_d = prod_q[15:8];
                // (RULE7) Product lower byte.
                `RMAC_OFS_PROD_LO: rdata_d = prod_q[7:0];
                // (RULE8) Accumulator bits 15..8.
                `RMAC_OFS_ACC_B1: rdata_d = acc_lo_q[15:8];
                // (RULE10) Accumulator bits 7..0.
                `RMAC_OFS_ACC_B0: rdata_d = acc_lo_q[7:0];
                // (RULE12) Accumulator bits 31..24.
                `RMAC_OFS_ACC_B3: rdata_d = acc_hi_q[15:8];
                // (RULE17) Accumulator bits 23..16.
                `RMAC_OFS_ACC_B2: rdata_d = acc_hi_q[7:0];
                default: rdata_d = `RMAC_RD_IDLE;
            endcase
        end
    end

    // Registered read data: valid the cycle after rd_en_i.
    always_ff @(posedge sys_clk_i or posedge rst_i) begin
        if (rst_i) begin
            rdata_o <= `RMAC_RD_IDLE;
        end else begin
            rdata_o <= rdata_d;
        end
    end

    // -----------------------------------------------------------------
    // Assertions
    // -----------------------------------------------------------------
    sequence s_acc_wr;
        wr_en_i && (addr_i == `RMAC_OFS_ACC_B1
                    || addr_i == `RMAC_OFS_ACC_B0);
    endsequence

    property p_prod_now; // (RULE3)
        @(posedge sys_clk_i) disable iff (rst_i)
        (wr_en_i && addr_i == `RMAC_OFS_MULT_X)
        |=> prod_q == 16'(signed'($past(wdata_i))) * 16'(opnd_y_q);
    endproperty
    a_prod_now: assert property (p_prod_now) // (RULE3)
        else $error("product not ready after X write");

    property p_mul_keeps_acc; // (RULE15)
        @(posedge sys_clk_i) disable iff (rst_i)
        (wr_en_i && addr_i == `RMAC_OFS_MULT_Y && !pend_q)
        |=> $stable({acc_hi_q, acc_lo_q});
    endproperty
    a_mul_keeps_acc: assert property (p_mul_keeps_acc) // (RULE15)
        else $error("plain multiply changed accumulator");

    property p_lo_acc; // (RULE2)
        @(posedge sys_clk_i) disable iff (rst_i)
        s_acc_wr |=> acc_lo_q == 16'($past(acc_lo_q) + prod_q);
    endproperty
    a_lo_acc: assert property (p_lo_acc) // (RULE2)
        else $error("low accumulator half not updated");

    property p_hi_acc; // (RULE18)
        @(posedge sys_clk_i) disable iff (rst_i)
        s_acc_wr ##1 (!wr_clr && !acc_go) |=> {acc_hi_q, acc_lo_q} ==
            $past({acc_hi_q, acc_lo_q}, 2) + 32'($past(prod_q));
    endproperty
    a_hi_acc: assert property (p_hi_acc) // (RULE18)
        else $error("upper accumulator half wrong after one cycle");

    property p_clear; // (RULE13)
        @(posedge sys_clk_i) disable iff (rst_i)
        wr_clr |=> acc_hi_q == 16'h0000 && acc_lo_q == 16'h0000;
    endproperty
    a_clear: assert property (p_clear) // (RULE13)
        else $error("accumulator not cleared");

    property p_x_shared; // (RULE16)
        @(posedge sys_clk_i) disable iff (rst_i)
        (wr_en_i && addr_i == `RMAC_OFS_ACC_B1) |=>
            opnd_x_q == $past(wdata_i) && $stable(opnd_y_q);
    endproperty
    a_x_shared: assert property (p_x_shared) // (RULE9)
        else $error("accumulate X write did not load operand");

    property p_rd_acc0; // (RULE10)
        @(posedge sys_clk_i) disable iff (rst_i)
        (rd_en_i && addr_i == `RMAC_OFS_ACC_B0)
        |=> rdata_o == $past(acc_lo_q[7:0]);
    endproperty
    a_rd_acc0: assert property (p_rd_acc0) // (RULE10)
        else $error("accumulator byte 0 read wrong");

    property p_rd_acc3; // (RULE12)
        @(posedge sys_clk_i) disable iff (rst_i)
        (rd_en_i && addr_i == `RMAC_OFS_ACC_B3)
        |=> rdata_o == $past(acc_hi_q[15:8]);
    endproperty
    a_rd_acc3: assert property (p_rd_acc3) // (RULE12)
        else $error("accumulator byte 3 read wrong");

    property p_rd_prod; // (RULE6)
        @(posedge sys_clk_i) disable iff (rst_i)
        (rd_en_i && addr_i == `RMAC_OFS_PROD_HI)
        |=> rdata_o == $past(prod_q[15:8]);
    endproperty
    a_rd_prod: assert property (p_rd_prod) // (RULE6)
        else $error("product high byte read wrong");

    property p_rd_idle; // (RULE4)
        @(posedge sys_clk_i) disable iff (rst_i)
        (!rd_en_i || addr_i == `RMAC_OFS_MULT_X
            || addr_i == `RMAC_OFS_MULT_Y) |=> rdata_o == `RMAC_RD_IDLE;
    endproperty
    a_rd_idle: assert property (p_rd_idle) // (RULE4)
        else $error("idle or write-only read returned data");
endmodule

// ==== verif/rmac_cpu_model.sv ====
/*
 * Processor-side model for the multiply/accumulate unit's register bus.
 * Assumes the bench calls access() at a falling edge, back to back.
 */
module rmac_cpu_model (
    input wire logic sys_clk_i,
    input wire rmac_pkg::rmac_data_t rdata_i,
    output logic wr_en_o,
    output logic rd_en_o,
    output rmac_pkg::rmac_addr_t addr_o,
    output rmac_pkg::rmac_data_t wdata_o
);
    timeunit 1ns;
    timeprecision 1ns;
    import rmac_pkg::*;
    logic acc_pend_q = 1'b0;

    // Bus lines start quiet so no request reaches the unit during reset.
    initial begin
        wr_en_o = 1'b0;
        rd_en_o = 1'b0;
        addr_o = 8'h00;
        wdata_o = 8'h00;
    end

    // One bus cycle; unused lines show a changing pattern, not old data.
    task automatic cycle(input logic w, input logic r, input rmac_addr_t a,
                         input rmac_data_t d);
        wr_en_o = w;
        rd_en_o = r;
        addr_o = (w | r) ? a : ~addr_o;
        wdata_o = w ? d : ~wdata_o;
        @(negedge sys_clk_i);
    endtask

    // One instruction; read data stands in the cycle after the strobe.
    task automatic access(input logic w, input rmac_addr_t a,
                          input rmac_data_t d, output rmac_data_t q);
        if (acc_pend_q && (a == 8'hee || a == 8'hef ||
            (w && (a == 8'hec || a == 8'hed)))) begin
            cycle(1'b0, 1'b0, a, d);
        end
        acc_pend_q = w && (a == 8'hec || a == 8'hed);
        cycle(w, !w, a, d);
        q = rdata_i;
    endtask
endmodule

// ==== verif/tb_top.sv ====
/*
 * Self-checking bench for the multiply/accumulate unit.
 * Assumes the processor model drives every bus request.
 */
module tb_top;
    timeunit 1ns;
    timeprecision 1ns;
    import rmac_pkg::*;
    logic sys_clk_i = 1'b0;
    logic rst_i = 1'b1;
    logic wr_en;
    logic rd_en;
    rmac_addr_t addr;
    rmac_data_t wdata;
    rmac_data_t rdata;
    rmac_opnd_t x_m = 8'sh00;
    rmac_opnd_t y_m = 8'sh00;
    rmac_acc_t acc_m = '0;
    int miscompares = 0;
    int checks = 0;

    rmac_top dut (.sys_clk_i(sys_clk_i), .rst_i(rst_i), .wr_en_i(wr_en),
        .rd_en_i(rd_en), .addr_i(addr), .wdata_i(wdata), .rdata_o(rdata));
    rmac_cpu_model cpu (.sys_clk_i(sys_clk_i), .rdata_i(rdata),
        .wr_en_o(wr_en), .rd_en_o(rd_en), .addr_o(addr), .wdata_o(wdata));

    // 20 MHz clock.
    initial begin
        forever #25 sys_clk_i = ~sys_clk_i;
    end

    // Expected read value from the bench's own operand and sum copies.
    function automatic rmac_data_t exp_rd(input rmac_addr_t a);
        rmac_prod_t p;
        p = rmac_prod_t'(x_m) * rmac_prod_t'(y_m);
        case (a)
            8'hea: return p[15:8];
            8'heb: return p[7:0];
            8'hec: return acc_m[15:8];
            8'hed: return acc_m[7:0];
            8'hef: return acc_m[23:16];
            8'hee: return acc_m[31:24];
            default: return 8'h00;
        endcase
    endfunction

    // Half the operands are the signed extremes, where sign slips show.
    function automatic rmac_data_t pick();
        case ($urandom_range(3, 0))
            0: return 8'h80;
            1: return 8'h7f;
            default: return rmac_data_t'($urandom);
        endcase
    endfunction

    task automatic chk(input rmac_addr_t a, input rmac_data_t seen,
                       input rmac_data_t exp);
        checks++;
        if (seen !== exp) begin
            miscompares++;
            $display("wrong value offset %h expected %h seen %h", a, exp,
                     seen);
        end
    endtask

    task automatic rd_chk(input rmac_addr_t a);
        rmac_data_t q;
        cpu.access(1'b0, a, 8'h00, q);
        chk(a, q, exp_rd(a));
    endtask

    // Write and track the effect on the bench's copies.
    task automatic wr(input rmac_addr_t a, input rmac_data_t d);
        rmac_data_t q;
        rmac_prod_t p;
        cpu.access(1'b1, a, d, q);
        if (a == 8'he8 || a == 8'hec) x_m = d;
        if (a == 8'he9 || a == 8'hed) y_m = d;
        p = rmac_prod_t'(x_m) * rmac_prod_t'(y_m);
        if (a == 8'hec || a == 8'hed) acc_m = acc_m + rmac_acc_t'(p);
        if (a == 8'hee || a == 8'hef) acc_m = '0;
    endtask

    task automatic rd_acc();
        rd_chk(8'hed);
        rd_chk(8'hec);
        rd_chk(8'hef);
        rd_chk(8'hee);
    endtask

    task automatic wrap_up();
        if (miscompares == 0 && checks > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask

    // Guard against a hung bus; the run needs well under 50 us.
    initial begin
        #200000;
        miscompares++;
        wrap_up();
    end

    // Reset values, then random multiply, accumulate and clear traffic.
    initial begin
        rmac_data_t d1;
        rmac_data_t d2;
        void'($urandom(32'hcedf));
        repeat (4) @(posedge sys_clk_i);
        @(negedge sys_clk_i);
        rst_i = 1'b0;
        for (int a = 'he8; a <= 'hef; a++) begin
            rd_chk(rmac_addr_t'(a));
        end
        rd_chk(8'h00);
        for (int i = 0; i < 80; i++) begin
            d1 = pick();
            d2 = pick();
            case ($urandom_range(4, 0))
                0: begin
                    wr(8'he8, d1);
                    wr(8'he9, d2);
                    rd_chk(8'hea);
                    rd_chk(8'heb);
                    rd_chk(8'hed);
                end
                1: begin
                    wr(8'he8, d1);
                    rd_chk(8'heb);
                    wr(8'hed, d2);
                    rd_acc();
                end
                2: begin
                    wr(8'he9, d1);
                    wr(8'hec, d2);
                    rd_acc();
                end
                3: begin
                    wr(8'hec, d1);
                    wr(8'hed, d2);
                    rd_acc();
                end
                default: begin
                    wr(d1[0] ? 8'hee : 8'hef, d2);
                    wr(8'hea, d1);
                    rd_chk(8'hea);
                    rd_acc();
                end
            endcase
        end
        // A mid-run reset must bring every register back to zero.
        cpu.cycle(1'b0, 1'b0, 8'h00, 8'h00);
        rst_i = 1'b1;
        repeat (2) @(negedge sys_clk_i);
        rst_i = 1'b0;
        x_m = '0;
        y_m = '0;
        acc_m = '0;
        for (int a = 'he8; a <= 'hef; a++) begin
            rd_chk(rmac_addr_t'(a));
        end
        wrap_up();
    end
endmodule
